// [core/qdhs_pkg.sv]
// Shared constants and types of the high-speed write receiver.
// Assumes nothing beyond a SystemVerilog compiler.
package qdhs_pkg;
   // Fixed upper part of the target address and of the high-speed controller code
   localparam logic [4:0] ADDR_FIXED  = 5'h13;
   localparam logic [4:0] MCODE_FIXED = 5'h01;
   localparam logic       RW_WRITE    = 1'h0;
   // Control byte fields
   localparam int CTRL_LOAD_HI = 5;
   localparam int CTRL_LOAD_LO = 4;
   localparam int CTRL_SEL_HI  = 2;
   localparam int CTRL_SEL_LO  = 1;
   localparam int CTRL_KIND    = 0;
   // Bit counter: bits 0..7, then the acknowledge clock
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] FIRST_CNT = 4'h1;
   // Channel register layout
   localparam int CH_N   = 4;
   localparam int DATA_W = 10;
   localparam int PD_W   = 2;
   localparam int REG_W  = PD_W + DATA_W;
   localparam logic [REG_W-1:0] REG_RST = 12'h000;
   localparam logic [PD_W-1:0]  PD_ON   = 2'h0;

   typedef enum logic [2:0] {
      ST_IDLE, ST_FIRST, ST_CTRL, ST_HI, ST_LO, ST_PD1, ST_PD2, ST_SKIP
   } qdhs_state_t;
endpackage

// [core/qdhs_word_if.sv]
// Carries one completed word from the receiver to the channel registers.
// Assumes valid is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface qdhs_word_if;
   logic       valid;
   logic [1:0] chan;
   logic [1:0] load;
   logic       kind;
   logic [9:0] code;
   logic [1:0] pd;
   modport src (output valid, output chan, output load, output kind, output code, output pd);
   modport dst (input valid, input chan, input load, input kind, input code, input pd);
endinterface
`default_nettype wire

// [core/qdhs_bank.sv]
// Per-channel staging and output registers.
// Assumes words arrive on the system clock; commits come from outside update logic.
`timescale 1ns/1ps
`default_nettype none
module qdhs_bank (
   input  wire logic             sys_clk_i,
   input  wire logic             rstn_i,
   qdhs_word_if.dst              word,
   input  wire logic [3:0]       commit_i,
   output logic      [47:0]      staging_o,
   output logic      [47:0]      output_o
);
   typedef struct packed {
      logic [qdhs_pkg::CH_N-1:0][qdhs_pkg::REG_W-1:0] stage;
      logic [qdhs_pkg::CH_N-1:0][qdhs_pkg::REG_W-1:0] outr;
   } qdhs_bank_t;

   qdhs_bank_t r;
   qdhs_bank_t n;

   always_comb begin
      n = r;
      // Commit takes the value held before this cycle's word
      for (int c = 0; c < qdhs_pkg::CH_N; c++) begin
         if (commit_i[c]) begin
            n.outr[c] = r.stage[c];
         end
      end
      if (word.valid) begin
         if (word.kind) begin
            // Power-down word keeps the channel's data bits
            n.stage[word.chan] = {word.pd, r.stage[word.chan][qdhs_pkg::DATA_W-1:0]};
         end else begin
            n.stage[word.chan] = {qdhs_pkg::PD_ON, word.code};
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign staging_o = r.stage;
   assign output_o  = r.outr;
endmodule
`default_nettype wire

// [core/qdhs_top.sv]
// High-speed write receiver of a quad-channel two-wire bus DAC target.
// Assumes scl_i is the bus clock line used as link clock; the pad resolves sda from sda_oe_o.
// Notes on behaviour
// - nobody acknowledges the controller code; ninth clock sees data high.
// - address is 10011, two pin bits, then write direction bit zero.
// - matching address is acknowledged by pulling data low on ninth clock.
// - control byte: load bits 5:4, channel bits 2:1, kind bit 0.
// - control byte after a matching address is acknowledged.
// - kind bit chooses data words or a power-down word.
// - data mode takes high and low byte pairs until next start or stop.
// - high data byte becomes code bits 9 down to 2.
// - low byte bits 7:6 become code bits 1:0; rest ignored.
// - power-down mode takes exactly two bytes for the selected channel.
// - channel bits pick which of four channels the write reaches.
// - each channel has a 12-bit staging register, power-down above data.
// - each channel has a 12-bit output register updated from staging.
`timescale 1ns/1ps
`default_nettype none
module qdhs_top (
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic        addr_pin_hi_i,
   input  wire logic        addr_pin_lo_i,
   input  wire logic [3:0]  commit_i,
   output logic             hs_mode_o,
   output logic             word_strobe_o,
   output logic      [1:0]  word_chan_o,
   output logic      [1:0]  word_load_o,
   output logic             word_kind_flag_o,
   output logic      [47:0] channel_staging_reg_o,
   output logic      [47:0] channel_output_reg_o
);
   typedef struct packed {
      qdhs_pkg::qdhs_state_t st;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic       ack;
      logic       hs;
      logic       start_seen;
      logic       stop_seen;
      logic [1:0] pin1;
      logic [1:0] pin2;
      logic [1:0] chan;
      logic [1:0] load;
      logic       kind;
      logic [7:0] hi;
      logic [1:0] w_chan;
      logic [1:0] w_load;
      logic       w_kind;
      logic [9:0] w_code;
      logic [1:0] w_pd;
      logic       w_tog;
   } qdhs_lnk_t;

   typedef struct packed {
      logic       t1;
      logic       t2;
      logic       t3;
      logic       h1;
      logic       h2;
      logic       valid;
      logic [1:0] chan;
      logic [1:0] load;
      logic       kind;
      logic [9:0] code;
      logic [1:0] pd;
   } qdhs_sys_t;

   qdhs_lnk_t   l_r;
   qdhs_lnk_t   l_nxt;
   qdhs_sys_t   s_r;
   qdhs_sys_t   s_nxt;
   logic        start_tog_r;
   logic        stop_tog_r;
   logic        oe_r;
   logic [7:0]  byte_v;
   logic        new_start;
   qdhs_word_if word ();

   // Start and stop are data edges while the clock line is high; no clock edge sees them
   always_ff @(negedge sda_i or negedge rstn_i) begin
      if (!rstn_i) begin
         start_tog_r <= 1'h0;
      end else if (scl_i) begin
         start_tog_r <= ~start_tog_r;
      end
   end

   always_ff @(posedge sda_i or negedge rstn_i) begin
      if (!rstn_i) begin
         stop_tog_r <= 1'h0;
      end else if (scl_i) begin
         stop_tog_r <= ~stop_tog_r;
      end
   end

   assign byte_v    = {l_r.sh[6:0], sda_i};
   assign new_start = start_tog_r != l_r.start_seen;

   always_comb begin
      l_nxt            = l_r;
      l_nxt.pin1       = {addr_pin_hi_i, addr_pin_lo_i};
      l_nxt.pin2       = l_r.pin1;
      l_nxt.start_seen = start_tog_r;
      l_nxt.stop_seen  = stop_tog_r;
      if (new_start) begin
         // First bit of the byte after a start or repeated start
         l_nxt.st  = qdhs_pkg::ST_FIRST;
         l_nxt.sh  = {7'h00, sda_i};
         l_nxt.cnt = qdhs_pkg::FIRST_CNT;
         l_nxt.ack = 1'h0;
         if (stop_tog_r != l_r.stop_seen) begin
            l_nxt.hs = 1'h0;
         end
      end else if (l_r.st == qdhs_pkg::ST_IDLE) begin
         l_nxt.cnt = 4'h0;
      end else if (l_r.cnt == qdhs_pkg::ACK_SLOT) begin
         l_nxt.cnt = 4'h0;
         l_nxt.ack = 1'h0;
      end else if (l_r.cnt == qdhs_pkg::LAST_BIT) begin
         l_nxt.cnt = qdhs_pkg::ACK_SLOT;
         l_nxt.sh  = byte_v;
         unique case (l_r.st)
            qdhs_pkg::ST_FIRST: begin
               if (!l_r.hs) begin
                  // Controller code is left unacknowledged; wait for the repeated start
                  if (byte_v[7:3] == qdhs_pkg::MCODE_FIXED) begin
                     l_nxt.hs = 1'h1;
                  end
                  l_nxt.st = qdhs_pkg::ST_IDLE;
               end else if (byte_v == {qdhs_pkg::ADDR_FIXED, l_r.pin2, qdhs_pkg::RW_WRITE}) begin
                  l_nxt.ack = 1'h1;
                  l_nxt.st  = qdhs_pkg::ST_CTRL;
               end else begin
                  l_nxt.st = qdhs_pkg::ST_SKIP;
               end
            end
            qdhs_pkg::ST_CTRL: begin
               l_nxt.ack  = 1'h1;
               l_nxt.load = byte_v[qdhs_pkg::CTRL_LOAD_HI:qdhs_pkg::CTRL_LOAD_LO];
               l_nxt.chan = byte_v[qdhs_pkg::CTRL_SEL_HI:qdhs_pkg::CTRL_SEL_LO];
               l_nxt.kind = byte_v[qdhs_pkg::CTRL_KIND];
               l_nxt.st   = byte_v[qdhs_pkg::CTRL_KIND] ? qdhs_pkg::ST_PD1 : qdhs_pkg::ST_HI;
            end
            qdhs_pkg::ST_HI, qdhs_pkg::ST_PD1: begin
               l_nxt.ack = 1'h1;
               l_nxt.hi  = byte_v;
               l_nxt.st  = (l_r.st == qdhs_pkg::ST_HI) ? qdhs_pkg::ST_LO : qdhs_pkg::ST_PD2;
            end
            qdhs_pkg::ST_LO, qdhs_pkg::ST_PD2: begin
               l_nxt.ack    = 1'h1;
               l_nxt.w_chan = l_r.chan;
               l_nxt.w_load = l_r.load;
               l_nxt.w_kind = l_r.kind;
               l_nxt.w_code = {l_r.hi, byte_v[7:6]};
               l_nxt.w_pd   = l_r.hi[7:6];
               l_nxt.w_tog  = ~l_r.w_tog;
               // Data words repeat; a power-down write takes two bytes only
               l_nxt.st = (l_r.st == qdhs_pkg::ST_LO) ? qdhs_pkg::ST_HI : qdhs_pkg::ST_SKIP;
            end
            qdhs_pkg::ST_SKIP: begin
               l_nxt.ack = 1'h0;
            end
            default: begin
               l_nxt.st = qdhs_pkg::ST_IDLE;
            end
         endcase
      end else begin
         l_nxt.sh  = byte_v;
         l_nxt.cnt = 4'(l_r.cnt + 4'h1);
      end
   end

   always_ff @(posedge scl_i or negedge rstn_i) begin
      if (!rstn_i) begin
         l_r <= '0;
      end else begin
         l_r <= l_nxt;
      end
   end

   // Data may only change while the clock line is low, hence the falling edge
   always_ff @(negedge scl_i or negedge rstn_i) begin
      if (!rstn_i) begin
         oe_r <= 1'h0;
      end else begin
         oe_r <= (l_r.cnt == qdhs_pkg::ACK_SLOT) && l_r.ack;
      end
   end

   assign sda_o    = 1'h0;
   assign sda_oe_o = oe_r;

   // Payload is held many link cycles after the toggle, so it is stable when sampled
   always_comb begin
      s_nxt       = s_r;
      s_nxt.t1    = l_r.w_tog;
      s_nxt.t2    = s_r.t1;
      s_nxt.t3    = s_r.t2;
      s_nxt.h1    = l_r.hs;
      s_nxt.h2    = s_r.h1;
      s_nxt.valid = s_r.t2 ^ s_r.t3;
      if (s_r.t2 ^ s_r.t3) begin
         s_nxt.chan = l_r.w_chan;
         s_nxt.load = l_r.w_load;
         s_nxt.kind = l_r.w_kind;
         s_nxt.code = l_r.w_code;
         s_nxt.pd   = l_r.w_pd;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign word.valid = s_r.valid;
   assign word.chan  = s_r.chan;
   assign word.load  = s_r.load;
   assign word.kind  = s_r.kind;
   assign word.code  = s_r.code;
   assign word.pd    = s_r.pd;

   assign hs_mode_o        = s_r.h2;
   assign word_strobe_o    = s_r.valid;
   assign word_chan_o      = s_r.chan;
   assign word_load_o      = s_r.load;
   assign word_kind_flag_o = s_r.kind;

   qdhs_bank u_bank (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .word      (word.dst),
      .commit_i  (commit_i),
      .staging_o (channel_staging_reg_o),
      .output_o  (channel_output_reg_o)
   );
endmodule
`default_nettype wire

// [tb/qdhs_monitor.sv]
// Checker of the high-speed write receiver, bound to its top module.
// Assumes the top module's port names; scl_i idles high outside frames.
`timescale 1ns/1ps
`default_nettype none
module qdhs_monitor (
   input wire logic        sys_clk_i,
   input wire logic        rstn_i,
   input wire logic        scl_i,
   input wire logic        sda_o,
   input wire logic        sda_oe_o,
   input wire logic        hs_mode_o,
   input wire logic [3:0]  commit_i,
   input wire logic        word_strobe_o,
   input wire logic [1:0]  word_chan_o,
   input wire logic [1:0]  word_load_o,
   input wire logic        word_kind_flag_o,
   input wire logic [47:0] channel_staging_reg_o,
   input wire logic [47:0] channel_output_reg_o
);
   a_ack_one_clock: assert property (@(posedge scl_i) disable iff (!rstn_i)
      sda_oe_o |=> !sda_oe_o [*8]) else $error("ack held past its clock");
   a_oe_scl_low: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      $changed(sda_oe_o) |-> !scl_i) else $error("ack moved while clock high");
   a_ack_pulls_low: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      sda_oe_o |-> !sda_o && hs_mode_o) else $error("ack high or outside high-speed mode");
   a_strobe_pulse: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      word_strobe_o |=> !word_strobe_o [*8]) else $error("word strobe too long");
   a_fields_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      !word_strobe_o |-> $stable({word_chan_o, word_load_o, word_kind_flag_o}))
      else $error("word fields moved without strobe");
   a_staging_cause: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      $changed(channel_staging_reg_o) |-> $past(word_strobe_o))
      else $error("staging changed without a word");
   a_output_cause: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      $changed(channel_output_reg_o) |-> $past(commit_i) != 4'h0)
      else $error("output changed without commit");
   a_commit_copy: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      commit_i[2] |=> channel_output_reg_o[35:24] == $past(channel_staging_reg_o[35:24]))
      else $error("commit did not copy staging");
   a_data_clears_pd: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      word_strobe_o && !word_kind_flag_o |=>
      channel_staging_reg_o[word_chan_o*12+10 +: 2] == 2'h0) else $error("data kept pd bits");
   a_pd_keeps_code: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      word_strobe_o && word_kind_flag_o |=> channel_staging_reg_o[word_chan_o*12 +: 10] ==
      $past(channel_staging_reg_o[word_chan_o*12 +: 10])) else $error("pd word changed code");
   c_data_word: cover property (@(posedge sys_clk_i) word_strobe_o && !word_kind_flag_o);
   c_pd_word: cover property (@(posedge sys_clk_i) word_strobe_o && word_kind_flag_o);
   c_ack: cover property (@(posedge scl_i) sda_oe_o);
endmodule
bind qdhs_top qdhs_monitor mon (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .scl_i(scl_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .hs_mode_o(hs_mode_o), .commit_i(commit_i),
   .word_strobe_o(word_strobe_o),
   .word_chan_o(word_chan_o), .word_load_o(word_load_o), .word_kind_flag_o(word_kind_flag_o),
   .channel_staging_reg_o(channel_staging_reg_o), .channel_output_reg_o(channel_output_reg_o));
`default_nettype wire

// [tb/qdhs_ctl_model.sv]
// Behavioural two-wire bus controller sending high-speed writes.
// Assumes the bench resolves the data wire with a pull-up; clock period 32 ns.
`timescale 1ns/1ps
`default_nettype none
module qdhs_ctl_model (
   output logic      scl_o,
   output logic      sda_low_o,
   input  wire logic sda_i
);
   localparam time Q = 8;
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // Start or repeated start; clock then rests low
   task automatic start();
      sda_low_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q sda_low_o = 1'b1;
      #Q scl_o = 1'b0;
   endtask
   task automatic stop();
      #Q sda_low_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_low_o = 1'b0;
      #Q;
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #Q sda_low_o = !b[i];
         #Q scl_o = 1'b1;
         #(2*Q) scl_o = 1'b0;
      end
      // Released wire lets the target answer, else pull-up gives the nack
      #Q sda_low_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q ack = !sda_i;
      #Q scl_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the high-speed write receiver.
// Assumes the controller model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        sys_clk_i = 1'b0;
   logic        rstn_i    = 1'b0;
   logic [3:0]  commit    = 4'h0;
   logic [1:0]  pins      = 2'b10;
   logic        scl, sda_low, sda_o, sda_oe, hs, strobe, kind, wkind;
   logic [1:0]  chan, load, wchan, wload;
   logic [47:0] stg, outr;
   int          mismatches = 0;
   int          tests_run  = 0;
   int          nwords     = 0;
   wire logic   sda = !(sda_low || (sda_oe && !sda_o));

   always #2.5 sys_clk_i = !sys_clk_i;
   // Strobe lasts one cycle, so latch the fields it qualifies
   always @(posedge sys_clk_i) if (strobe === 1'b1) begin
      {wchan, wload, wkind} <= {chan, load, kind};
      nwords <= nwords + 1;
   end

   qdhs_top uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_pin_hi_i(pins[1]), .addr_pin_lo_i(pins[0]),
      .commit_i(commit), .hs_mode_o(hs), .word_strobe_o(strobe), .word_chan_o(chan),
      .word_load_o(load), .word_kind_flag_o(kind), .channel_staging_reg_o(stg),
      .channel_output_reg_o(outr));
   qdhs_ctl_model ctl (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));

   task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tx(input logic [7:0] b, input logic exp);
      logic a;
      ctl.send(b, a);
      tests_run++;
      if (a !== exp) begin
         mismatches++;
         $display("BAD t=%0t ack %b on byte %h", $time, a, b);
      end
   endtask
   task automatic head(input logic [7:0] ctrl);
      ctl.start();
      tx(8'h9c, 1'b1);
      tx(ctrl, 1'b1);
   endtask
   task automatic close_out();
      $display("compared %0d, bad %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #60us;
      mismatches++;
      $display("BAD t=%0t watchdog expired", $time);
      close_out();
   end

   initial begin
      repeat (5) @(negedge sys_clk_i);
      rstn_i = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      ctl.start();
      tx(8'h0b, 1'b0);
      chk_val({11'h0, hs}, 12'h001);
      head(8'h14);
      tx(8'ha5, 1'b1);
      tx(8'hff, 1'b1);
      chk_val(stg[35:24], 12'h297);
      chk_val({7'h0, wchan, wload, wkind}, 12'h012);
      tx(8'h3c, 1'b1);
      tx(8'h40, 1'b1);
      chk_val(stg[35:24], 12'h0f1);
      chk_val(nwords[11:0], 12'h002);
      $display("test data words done");
      head(8'h23);
      tx(8'h80, 1'b1);
      tx(8'h00, 1'b1);
      tx(8'h55, 1'b0);
      chk_val(stg[23:12], 12'h800);
      chk_val({7'h0, wchan, wload, wkind}, 12'h00d);
      $display("test power-down word done");
      ctl.start();
      tx(8'h9a, 1'b0);
      ctl.stop();
      @(negedge sys_clk_i) commit = 4'h6;
      @(negedge sys_clk_i) commit = 4'h0;
      @(negedge sys_clk_i);
      chk_val(outr[35:24], 12'h0f1);
      chk_val(outr[23:12], 12'h800);
      chk_val(outr[11:0], 12'h000);
      chk_val(stg[11:0], 12'h000);
      $display("test address and commit done");
      // New strap levels must move the matching address; pd bits must clear
      @(negedge sys_clk_i) pins = 2'b01;
      ctl.start();
      tx(8'h08, 1'b0);
      ctl.start();
      tx(8'h9a, 1'b1);
      tx(8'h12, 1'b1);
      tx(8'hc0, 1'b1);
      tx(8'h80, 1'b1);
      chk_val(stg[23:12], 12'h302);
      chk_val({7'h0, wchan, wload, wkind}, 12'h00a);
      ctl.stop();
      $display("test pins and reload done");
      ctl.start();
      tx(8'h9c, 1'b0);
      chk_val({11'h0, hs}, 12'h000);
      ctl.stop();
      $display("test low-speed frame done");
      close_out();
   end
endmodule
`default_nettype wire
